//--- core/tcp_pkg.sv
package tcp_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_CHAN = 5'h04;
  localparam logic [4:0] OFS_IEN = 5'h08;
  localparam logic [4:0] OFS_STAT = 5'h0C;
  localparam logic [4:0] OFS_EVGEN = 5'h10;
  localparam logic [4:0] OFS_CNT = 5'h14;
  localparam logic [4:0] OFS_ARR = 5'h18;
  localparam logic [4:0] OFS_CCR = 5'h1C;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_RUN = 0;
  localparam int CTRL_DIR = 4;
  localparam int CTRL_CTRM = 5;
  localparam int CTRL_RLDPE = 7;
  localparam int CHAN_MODE = 0;
  localparam int CHAN_OCPE = 3;
  localparam int CHAN_POL = 4;
  localparam int CHAN_CCE = 5;
  localparam int CHAN_CCNE = 6;
  localparam int CHAN_MAIN = 7;
  localparam int CHAN_IDLE_OFF = 8;
  localparam int CHAN_RUN_OFF = 9;
  localparam int CHAN_DSEL = 10;
  localparam int IEN_IRQ = 0;
  localparam int IEN_DMA = 1;
  localparam int STAT_MATCH = 0;
  localparam int STAT_UPD = 1;
  localparam int EVGEN_UPD = 0;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] ARR_RST = 16'hFFFF;
  localparam logic [15:0] CCR_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;

  // ****************************************
  // modes
  // ****************************************
  typedef enum logic [2:0] {
    MODE_HOLD = 3'h0,
    MODE_ACT = 3'h1,
    MODE_INACT = 3'h2,
    MODE_TOGGLE = 3'h3,
    MODE_LOW = 3'h4,
    MODE_HIGH = 3'h5,
    MODE_PWM1 = 3'h6,
    MODE_PWM2 = 3'h7
  } tcp_mode_t;

  typedef enum logic [1:0] {
    CTR_EDGE = 2'h0,
    CTR_DOWN = 2'h1,
    CTR_UP = 2'h2,
    CTR_BOTH = 2'h3
  } tcp_ctr_t;

endpackage

//--- core/tcp_channel.sv
`timescale 1ns/100ps
// Behaviour
// - on match, mode 000 holds, 001 sets, 010 clears, 011 toggles reference.
// - a compare match sets the channel match flag; center modes 01 and 10 flag in one direction only.
// - interrupt request only while the channel interrupt enable is set.
// - dma request when enabled; select bit picks match or update event.
// - no preload: compare write immediate; preload: copied on update event.
// - update event never changes reference or output in compare modes.
// - mode 110 is pwm mode 1, mode 111 is pwm mode 2.
// - polarity bit makes the output active high or active low.
// - output enable from channel, complementary, main enables and off-states.
// - pwm edge aligned or center aligned per center mode field.
// - counter counts up with direction low, down with direction high.
// - up pwm1 high while count below compare; ccr above reload high, zero low.
// - down pwm1 low while count above compare; no zero duty.
// - center counting whenever center mode is nonzero, same waveform.
// - center flagging by direction; 01 flags while counting down only.
// - hardware owns direction in center mode; control writes leave it alone.
// - center start loads direction from the same control write; leaving center keeps the held direction.
// - counter write above reload keeps the direction in center mode.
// - in center mode, counter write of zero or reload sets direction, no update event.
// - mode 100 forces reference low, 101 forces it high.
module tcp_channel #(
  parameter int W = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [4:0] addr,
  input wire logic [W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [W-1:0] rdata,
  output logic ch_out,
  output logic ch_out_en,
  output logic channel_reference_wave,
  output logic update_event_pulse,
  output logic irq_req,
  output logic dma_req
);

  // ****************************************
  // state
  // ****************************************
  logic run, dir, rld_pre, ocpe, pol, cce, ccne, main_en, idle_off, run_off;
  logic dsel;
  logic irq_en, dma_en, flag_match, flag_upd;
  tcp_pkg::tcp_ctr_t ctr_mode;
  tcp_pkg::tcp_mode_t mode;
  logic [W-1:0] cnt, arr_pre, arr_act, ccr_pre, ccr_act;
  logic next_ref, next_dir;
  logic [W-1:0] ctrl_word, chan_word, rd_mux;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
    return a == o;
  endfunction

  // ****************************************
  // decode
  // ****************************************
  wire wr_ctrl = wr_stb && hit(addr, tcp_pkg::OFS_CTRL);
  wire wr_chan = wr_stb && hit(addr, tcp_pkg::OFS_CHAN);
  wire wr_ien = wr_stb && hit(addr, tcp_pkg::OFS_IEN);
  wire wr_stat = wr_stb && hit(addr, tcp_pkg::OFS_STAT);
  wire wr_cnt = wr_stb && hit(addr, tcp_pkg::OFS_CNT);
  wire wr_arr = wr_stb && hit(addr, tcp_pkg::OFS_ARR);
  wire wr_ccr = wr_stb && hit(addr, tcp_pkg::OFS_CCR);
  wire sw_upd = wr_stb && hit(addr, tcp_pkg::OFS_EVGEN)
    && wdata[tcp_pkg::EVGEN_UPD];

  // ****************************************
  // counter
  // ****************************************
  wire center = ctr_mode != tcp_pkg::CTR_EDGE;
  wire at_top = cnt == arr_act;
  wire at_zero = cnt == '0;
  wire [W-1:0] cnt_inc = cnt + W'(1);
  wire [W-1:0] cnt_dec = cnt - W'(1);
  wire turn = center ? ((!dir && at_top) || (dir && at_zero))
    : (dir ? at_zero : at_top);
  // a counter write never raises an update
  wire ovf = run && !wr_cnt && turn;
  wire upd_evt = sw_upd || ovf;
  wire [W-1:0] run_cnt = center
    ? (dir ? (at_zero ? cnt_inc : cnt_dec)
       : (at_top ? cnt_dec : cnt_inc))
    : (dir ? (at_zero ? arr_act : cnt_dec)
       : (at_top ? '0 : cnt_inc));
  wire [W-1:0] next_cnt = sw_upd ? ((dir && !center) ? arr_act : '0)
    : wr_cnt ? wdata : run ? run_cnt : cnt;

  always_comb
  begin
    next_dir = dir;
    if (center)
    begin
      if (wr_cnt)
      begin
        if (wdata == '0)
          next_dir = 1'b0;
        else if (wdata == arr_act)
          next_dir = 1'b1;
        else
          next_dir = dir;
      end
      else if (run && turn)
        next_dir = !dir;
    end
    else if (wr_ctrl)
      next_dir = wdata[tcp_pkg::CTRL_DIR];
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cnt <= W'(tcp_pkg::CNT_RST);
      dir <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      dir <= next_dir;
    end
  end

  // ****************************************
  // configuration
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      run <= 1'b0;
      ctr_mode <= tcp_pkg::CTR_EDGE;
      rld_pre <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      run <= wdata[tcp_pkg::CTRL_RUN];
      ctr_mode <= tcp_pkg::tcp_ctr_t'(wdata[tcp_pkg::CTRL_CTRM +: 2]);
      rld_pre <= wdata[tcp_pkg::CTRL_RLDPE];
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      mode <= tcp_pkg::MODE_HOLD;
      {ocpe, pol, cce, ccne, main_en, idle_off, run_off, dsel} <= 8'h00;
    end
    else if (wr_chan)
    begin
      mode <= tcp_pkg::tcp_mode_t'(wdata[tcp_pkg::CHAN_MODE +: 3]);
      ocpe <= wdata[tcp_pkg::CHAN_OCPE];
      pol <= wdata[tcp_pkg::CHAN_POL];
      cce <= wdata[tcp_pkg::CHAN_CCE];
      ccne <= wdata[tcp_pkg::CHAN_CCNE];
      main_en <= wdata[tcp_pkg::CHAN_MAIN];
      idle_off <= wdata[tcp_pkg::CHAN_IDLE_OFF];
      run_off <= wdata[tcp_pkg::CHAN_RUN_OFF];
      dsel <= wdata[tcp_pkg::CHAN_DSEL];
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      {irq_en, dma_en} <= 2'h0;
    else if (wr_ien)
    begin
      irq_en <= wdata[tcp_pkg::IEN_IRQ];
      dma_en <= wdata[tcp_pkg::IEN_DMA];
    end
  end

  // ****************************************
  // preload and shadow
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      arr_pre <= W'(tcp_pkg::ARR_RST);
      arr_act <= W'(tcp_pkg::ARR_RST);
      ccr_pre <= W'(tcp_pkg::CCR_RST);
      ccr_act <= W'(tcp_pkg::CCR_RST);
    end
    else
    begin
      if (wr_arr)
        arr_pre <= wdata;
      if (wr_arr && !rld_pre)
        arr_act <= wdata;
      else if (upd_evt)
        arr_act <= arr_pre;
      if (wr_ccr)
        ccr_pre <= wdata;
      if (wr_ccr && !ocpe)
        ccr_act <= wdata;
      else if (upd_evt)
        ccr_act <= ccr_pre;
    end
  end

  // ****************************************
  // compare and reference
  // ****************************************
  wire match = run && (cnt == ccr_act);
  wire flag_dir_ok = (ctr_mode == tcp_pkg::CTR_EDGE)
    || (ctr_mode == tcp_pkg::CTR_BOTH)
    || (ctr_mode == tcp_pkg::CTR_DOWN && dir)
    || (ctr_mode == tcp_pkg::CTR_UP && !dir);
  wire match_evt = match && flag_dir_ok;
  // up: below compare; down: not above compare
  wire pwm1 = dir ? (cnt <= ccr_act) : (cnt < ccr_act);

  // update event is not an input here, so compare modes ignore it
  always_comb
  begin
    case (mode)
      tcp_pkg::MODE_HOLD: next_ref = channel_reference_wave;
      tcp_pkg::MODE_ACT: next_ref = match | channel_reference_wave;
      tcp_pkg::MODE_INACT: next_ref = !match & channel_reference_wave;
      tcp_pkg::MODE_TOGGLE: next_ref = match ^ channel_reference_wave;
      tcp_pkg::MODE_LOW: next_ref = 1'b0;
      tcp_pkg::MODE_HIGH: next_ref = 1'b1;
      tcp_pkg::MODE_PWM1: next_ref = pwm1;
      tcp_pkg::MODE_PWM2: next_ref = !pwm1;
      default: next_ref = 1'b0;
    endcase
  end

  // ****************************************
  // output stage
  // ****************************************
  wire next_out = (cce && main_en) ? (next_ref ^ pol) : pol;
  wire next_out_en = main_en ? (cce | (run_off & ccne))
    : (idle_off & (cce | ccne));

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      channel_reference_wave <= 1'b0;
      ch_out <= 1'b0;
      ch_out_en <= 1'b0;
    end
    else
    begin
      channel_reference_wave <= next_ref;
      ch_out <= next_out;
      ch_out_en <= next_out_en;
    end
  end

  // ****************************************
  // flags and requests
  // ****************************************
  wire clr_match = wr_stat && !wdata[tcp_pkg::STAT_MATCH];
  wire clr_upd = wr_stat && !wdata[tcp_pkg::STAT_UPD];
  wire dma_evt = dsel ? upd_evt : match_evt;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      flag_match <= 1'b0;
      flag_upd <= 1'b0;
      dma_req <= 1'b0;
      update_event_pulse <= 1'b0;
    end
    else
    begin
      flag_match <= match_evt | (flag_match & !clr_match);
      flag_upd <= upd_evt | (flag_upd & !clr_upd);
      dma_req <= dma_en & dma_evt;
      update_event_pulse <= upd_evt;
    end
  end

  assign irq_req = irq_en & flag_match;

  // ****************************************
  // read back
  // ****************************************
  always_comb
  begin
    ctrl_word = '0;
    ctrl_word[tcp_pkg::CTRL_RUN] = run;
    ctrl_word[tcp_pkg::CTRL_DIR] = dir;
    ctrl_word[tcp_pkg::CTRL_CTRM +: 2] = ctr_mode;
    ctrl_word[tcp_pkg::CTRL_RLDPE] = rld_pre;
    chan_word = '0;
    chan_word[tcp_pkg::CHAN_MODE +: 3] = mode;
    chan_word[tcp_pkg::CHAN_OCPE] = ocpe;
    chan_word[tcp_pkg::CHAN_POL] = pol;
    chan_word[tcp_pkg::CHAN_CCE] = cce;
    chan_word[tcp_pkg::CHAN_CCNE] = ccne;
    chan_word[tcp_pkg::CHAN_MAIN] = main_en;
    chan_word[tcp_pkg::CHAN_IDLE_OFF] = idle_off;
    chan_word[tcp_pkg::CHAN_RUN_OFF] = run_off;
    chan_word[tcp_pkg::CHAN_DSEL] = dsel;
  end

  assign rd_mux = hit(addr, tcp_pkg::OFS_CTRL) ? ctrl_word
    : hit(addr, tcp_pkg::OFS_CHAN) ? chan_word
    : hit(addr, tcp_pkg::OFS_IEN) ? W'({dma_en, irq_en})
    : hit(addr, tcp_pkg::OFS_STAT) ? W'({flag_upd, flag_match})
    : hit(addr, tcp_pkg::OFS_CNT) ? cnt
    : hit(addr, tcp_pkg::OFS_ARR) ? arr_pre
    : hit(addr, tcp_pkg::OFS_CCR) ? ccr_pre
    : '0;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      rdata <= '0;
    else
      rdata <= rd_stb ? rd_mux : '0;
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_ccr_direct;
    wr_ccr && !ocpe;
  endsequence

  sequence s_ccr_held;
    wr_ccr && ocpe && !upd_evt;
  endsequence

  a_flag_on_match: assert property (
    match_evt |=> flag_match)
    else $error("match flag not set");
  a_irq_gate: assert property (
    irq_req |-> irq_en && flag_match)
    else $error("interrupt without enable");
  a_dma_gate: assert property (
    dma_req |-> $past(dma_en) && $past(dma_evt))
    else $error("dma request without cause");
  a_ccr_direct: assert property (
    s_ccr_direct |=> ccr_act == $past(wdata))
    else $error("compare write not immediate");
  a_ccr_held: assert property (
    s_ccr_held |=> ccr_act == $past(ccr_act))
    else $error("shadow changed without update");
  a_toggle_match: assert property (
    mode == tcp_pkg::MODE_TOGGLE && match
    |=> channel_reference_wave != $past(channel_reference_wave))
    else $error("toggle missed");
  a_oc_no_upd: assert property (
    mode == tcp_pkg::MODE_HOLD && upd_evt
    |=> $stable(channel_reference_wave))
    else $error("update moved reference");
  a_pwm1_up: assert property (
    mode == tcp_pkg::MODE_PWM1 && !dir
    |=> channel_reference_wave == ($past(cnt) < $past(ccr_act)))
    else $error("pwm1 up level wrong");
  a_pwm2_down: assert property (
    mode == tcp_pkg::MODE_PWM2 && dir
    |=> channel_reference_wave == ($past(cnt) > $past(ccr_act)))
    else $error("pwm2 down level wrong");
  a_force_low: assert property (
    mode == tcp_pkg::MODE_LOW [*2] |-> !channel_reference_wave)
    else $error("forced low not low");
  a_dir_turn: assert property (
    center && run && !dir && at_top && !wr_cnt && !sw_upd |=> dir)
    else $error("no turn at top");
  a_cnt_wr_no_upd: assert property (
    wr_cnt && !sw_upd |=> !update_event_pulse)
    else $error("counter write raised update");
  a_pol_out: assert property (
    cce && main_en |=> ch_out == (channel_reference_wave ^ $past(pol)))
    else $error("polarity wrong");

endmodule

//--- dv/tcp_pin_load.sv
`timescale 1ns/100ps
// ****************************************
// pin load with pull-down
// ****************************************
module tcp_pin_load (
  input wire logic ch_out,
  input wire logic ch_out_en,
  output logic pin
);
  // released pin falls to the pull-down level
  assign pin = ch_out_en ? ch_out : 1'b0;
endmodule

//--- dv/test_tcp_channel.sv
`timescale 1ns/100ps
module test_tcp_channel;
  localparam logic [15:0] EN = (16'h0001 << tcp_pkg::CHAN_CCE)
    | (16'h0001 << tcp_pkg::CHAN_MAIN);
  localparam logic [15:0] OCPE = 16'h0001 << tcp_pkg::CHAN_OCPE;
  localparam logic [15:0] POL = 16'h0001 << tcp_pkg::CHAN_POL;
  localparam logic [15:0] DSEL = 16'h0001 << tcp_pkg::CHAN_DSEL;
  localparam logic [15:0] RUN = 16'h0001 << tcp_pkg::CTRL_RUN;
  localparam logic [15:0] RLDPE = 16'h0001 << tcp_pkg::CTRL_RLDPE;
  localparam logic [15:0] CTR1 = 16'h0001 << tcp_pkg::CTRL_CTRM;
  localparam logic [15:0] DIR = 16'h0001 << tcp_pkg::CTRL_DIR;
  logic clock;
  logic sys_rst;
  logic [4:0] addr;
  logic [15:0] wdata;
  logic wr_stb;
  logic rd_stb;
  logic [15:0] rdata;
  logic ch_out, ch_out_en, ref_w, upd, irq_req, dma_req, pin, rd_d, e, o;
  logic [4:0] b;
  logic [15:0] exp_q[$];
  int n_mismatch, tests_run, n_ref, n_tog, n_dma, n_upd, n_dh, c;

  tcp_channel #(.W(16)) i_dut (.clock(clock), .sys_rst(sys_rst),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .ch_out(ch_out), .ch_out_en(ch_out_en),
    .channel_reference_wave(ref_w), .update_event_pulse(upd),
    .irq_req(irq_req), .dma_req(dma_req));
  tcp_pin_load i_load (.ch_out(ch_out), .ch_out_en(ch_out_en), .pin(pin));

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ****************************************
  // checks and bus tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string m);
    tests_run++;
    if (got !== exp)
    begin
      $display("MISMATCH at %0t: %s", $time, m);
      n_mismatch++;
    end
  endtask

  task automatic chk_pins(input logic [3:0] x, input string m);
    chk(16'({ref_w, ch_out, ch_out_en, pin}), 16'(x), m);
  endtask

  task automatic close_out;
    if (n_mismatch == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] x);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    exp_q.push_back(x);
    @(posedge clock);
    rd_stb <= 1'b0;
  endtask

  function automatic logic [15:0] cf(input tcp_pkg::tcp_mode_t m,
                                     input logic [15:0] x);
    return x | {13'h0000, m};
  endfunction

  // counts reference highs, toggles and pulses over n cycles
  task automatic meas(input int n);
    logic last;
    repeat (3) @(posedge clock);
    n_ref = 0;
    n_tog = 0;
    n_dma = 0;
    n_upd = 0;
    n_dh = 0;
    last = ref_w;
    repeat (n)
    begin
      @(posedge clock);
      n_ref += int'(ref_w);
      n_tog += int'(ref_w != last);
      last = ref_w;
      n_dma += int'(dma_req);
      n_dh += int'(dma_req && ref_w);
      n_upd += int'(upd);
    end
  endtask

  always @(posedge clock)
  begin
    rd_d <= rd_stb;
    if (rd_d === 1'b1 && exp_q.size() > 0)
      chk(rdata, exp_q.pop_front(), "read data");
  end

  initial
  begin
    repeat (50000) @(posedge clock);
    n_mismatch++;
    close_out;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    sys_rst = 1'b1;
    addr = 5'h00;
    wdata = 16'h0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    n_mismatch = 0;
    tests_run = 0;
    void'($urandom(47629));
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    rd(tcp_pkg::OFS_ARR, tcp_pkg::ARR_RST);
    rd(tcp_pkg::OFS_CCR, tcp_pkg::CCR_RST);
    rd(tcp_pkg::OFS_CNT, tcp_pkg::CNT_RST);
    rd(tcp_pkg::OFS_EVGEN, 16'h0000);
    rd(5'h1E, 16'h0000);
    wr(tcp_pkg::OFS_ARR, 16'h0008);
    rd(tcp_pkg::OFS_ARR, 16'h0008);
    wr(tcp_pkg::OFS_CHAN, cf(tcp_pkg::MODE_HIGH, EN));
    repeat (3) @(posedge clock);
    chk_pins(4'hF, "forced high");
    wr(tcp_pkg::OFS_CHAN, cf(tcp_pkg::MODE_HIGH, EN | POL));
    repeat (3) @(posedge clock);
    chk_pins(4'hA, "inverted pin");
    wr(tcp_pkg::OFS_CHAN, cf(tcp_pkg::MODE_LOW, EN));
    repeat (3) @(posedge clock);
    chk_pins(4'h2, "forced low");
    wr(tcp_pkg::OFS_CTRL, RUN);
    wr(tcp_pkg::OFS_CCR, 16'h0004);
    wr(tcp_pkg::OFS_CHAN, cf(tcp_pkg::MODE_ACT, EN));
    repeat (12) @(posedge clock);
    chk_pins(4'hF, "set on match");
    wr(tcp_pkg::OFS_CHAN, cf(tcp_pkg::MODE_HOLD, EN));
    wr(tcp_pkg::OFS_EVGEN, 16'h0001);
    repeat (12) @(posedge clock);
    chk_pins(4'hF, "hold through update");
    wr(tcp_pkg::OFS_CHAN, cf(tcp_pkg::MODE_INACT, EN));
    repeat (12) @(posedge clock);
    chk_pins(4'h2, "clear on match");
    wr(tcp_pkg::OFS_CHAN, cf(tcp_pkg::MODE_TOGGLE, EN));
    meas(18);
    chk(16'(n_tog), 16'h0002, "toggle count");
    chk(16'(n_upd), 16'h0002, "update count");
    wr(tcp_pkg::OFS_IEN, 16'h0001 << tcp_pkg::IEN_IRQ);
    wr(tcp_pkg::OFS_CCR, 16'h0009);
    wr(tcp_pkg::OFS_STAT, 16'h0000);
    repeat (12) @(posedge clock);
    chk(16'(irq_req), 16'h0000, "no match no irq");
    wr(tcp_pkg::OFS_CCR, 16'h0003);
    repeat (12) @(posedge clock);
    chk(16'(irq_req), 16'h0001, "match irq");
    wr(tcp_pkg::OFS_IEN, 16'h0001 << tcp_pkg::IEN_DMA);
    repeat (2) @(posedge clock);
    chk(16'(irq_req), 16'h0000, "irq masked");
    meas(18);
    chk(16'(n_dma), 16'h0002, "dma on match");
    wr(tcp_pkg::OFS_CCR, 16'h0009);
    meas(18);
    chk(16'(n_dma), 16'h0000, "dma no match");
    wr(tcp_pkg::OFS_CHAN, cf(tcp_pkg::MODE_TOGGLE, EN | DSEL));
    meas(18);
    chk(16'(n_dma), 16'h0002, "dma on update");
    wr(tcp_pkg::OFS_CTRL, RUN | RLDPE);
    repeat (4)
    begin
      c = $urandom % 10;
      wr(tcp_pkg::OFS_CHAN, cf(tcp_pkg::MODE_PWM1, EN | OCPE));
      wr(tcp_pkg::OFS_CCR, 16'(c));
      wr(tcp_pkg::OFS_EVGEN, 16'h0001);
      meas(18);
      chk(16'(n_ref), 16'(2 * c), "pwm1 up");
      wr(tcp_pkg::OFS_CHAN, cf(tcp_pkg::MODE_PWM2, EN | OCPE));
      meas(18);
      chk(16'(n_ref), 16'(18 - 2 * c), "pwm2 up");
      wr(tcp_pkg::OFS_CHAN, cf(tcp_pkg::MODE_PWM1, EN | OCPE));
      wr(tcp_pkg::OFS_CTRL, RUN | RLDPE | DIR);
      wr(tcp_pkg::OFS_EVGEN, 16'h0001);
      meas(18);
      chk(16'(n_ref), 16'(2 * ((c < 9) ? c + 1 : 9)), "pwm1 down");
      wr(tcp_pkg::OFS_CTRL, RUN | RLDPE);
    end
    wr(tcp_pkg::OFS_CCR, 16'h0004);
    for (int m = 1; m < 4; m++)
    begin
      wr(tcp_pkg::OFS_CTRL, RUN | RLDPE | CTR1 * 16'(m));
      wr(tcp_pkg::OFS_EVGEN, 16'h0001);
      meas(32);
      chk(16'(n_ref), 16'h0010, "center pwm1");
      chk(16'(n_dma), (m == 3) ? 16'h0004 : 16'h0002, "center flag");
      chk(16'(n_dh), (m == 2) ? 16'h0000 : 16'h0002, "flag dir");
      wr(tcp_pkg::OFS_CTRL, RUN | RLDPE);
    end
    wr(tcp_pkg::OFS_CTRL, RUN | RLDPE | CTR1);
    wr(tcp_pkg::OFS_CHAN, cf(tcp_pkg::MODE_PWM2, EN | OCPE));
    wr(tcp_pkg::OFS_EVGEN, 16'h0001);
    meas(32);
    chk(16'(n_ref), 16'h0010, "center pwm2");
    wr(tcp_pkg::OFS_CNT, 16'h0000);
    rd(tcp_pkg::OFS_CTRL, RUN | RLDPE | CTR1);
    wr(tcp_pkg::OFS_CNT, 16'h0008);
    rd(tcp_pkg::OFS_CTRL, RUN | RLDPE | CTR1 | DIR);
    wr(tcp_pkg::OFS_CNT, 16'h000C);
    rd(tcp_pkg::OFS_CTRL, RUN | RLDPE | CTR1 | DIR);
    wr(tcp_pkg::OFS_CTRL, 16'h0000);
    for (int i = 0; i < 32; i++)
    begin
      b = i[4:0];
      e = b[2] ? (b[0] | (b[4] & b[1])) : (b[3] & (b[0] | b[1]));
      o = b[0] & b[2];
      wr(tcp_pkg::OFS_CHAN, cf(tcp_pkg::MODE_HIGH, {6'h00, b, 5'h00}));
      repeat (3) @(posedge clock);
      chk_pins({1'b1, o, e, e & o}, "output enable");
    end
    repeat (4) @(posedge clock);
    close_out;
  end
endmodule
